// File: pkg/core_params.svh
// offsets, field positions, reset values and encodings of the execution core
`ifndef CORE_PARAMS_SVH
`define CORE_PARAMS_SVH
`define REG_CTRL        5'h00
`define REG_PC          5'h04
`define REG_CORE        5'h08
`define REG_PROD        5'h0c
`define REG_PTR01       5'h10
`define REG_TBLPTR      5'h14
`define REG_PTR2        5'h18
`define CTRL_RUN_BIT    0
`define CTRL_WAKE_BIT   1
`define CTRL_SWCLR_BIT  2
`define CTRL_RUN_RST    1'b0
`define FLAG_C          0
`define FLAG_DC         1
`define FLAG_Z          2
`define FLAG_OV         3
`define FLAG_N          4
`define PORT_ADDR       12'hf81
`define TIMER0_ADDR     12'hfd6
`define ACCESS_SPLIT    8'h80
`define ACCESS_HIGH     4'hf
`define STACK_DEPTH     31
`define OP_NOP          16'h0000
`define OP_SLEEP        16'h0003
`define OP_WDT_CLEAR    16'h0004
`define OP_PUSH         16'h0005
`define OP_POP          16'h0006
`define OP_SW_RESET     16'h00ff
`endif

// File: pkg/core_pkg.sv
// types shared by the execution core and its helpers
package core_pkg;
  typedef enum logic [2:0] {ST_EXEC, ST_SECOND, ST_FLUSH, ST_TABLE, ST_SLEEP} state_type;
  typedef enum logic [2:0] {ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_MOV,
                            ALU_MUL} alu_op_type;
endpackage

// File: src/constant_alu.sv
// literal arithmetic and logic with flag results
`timescale 1ns/1ps
`include "core_params.svh"
module constant_alu
  import core_pkg::*;
(
  input  wire alu_op_type op,
  input  wire logic [7:0] acc,
  input  wire logic [7:0] k,
  output logic      [7:0] res,
  output logic      [4:0] flags,
  output logic      [4:0] flag_mask,
  output logic     [15:0] prod
);
  logic [8:0] sum;
  logic [4:0] low;
  always_comb begin
    sum       = 9'h000;
    low       = 5'h00;
    flags     = 5'h00;
    flag_mask = 5'h00;
    prod      = acc * k;
    case (op)
      ALU_ADD: begin
        sum = {1'b0, acc} + {1'b0, k};
        low = {1'b0, acc[3:0]} + {1'b0, k[3:0]};
        res = sum[7:0];
        flags[`FLAG_OV] = ~(acc[7] ^ k[7]) & (res[7] ^ acc[7]);
      end
      ALU_SUB: begin
        // carry and digit carry mean no borrow
        sum = {1'b0, k} + {1'b0, ~acc} + 9'h001;
        low = {1'b0, k[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
        res = sum[7:0];
        flags[`FLAG_OV] = (k[7] ^ acc[7]) & (res[7] ^ k[7]);
      end
      ALU_AND: res = acc & k;
      ALU_OR:  res = acc | k;
      ALU_XOR: res = acc ^ k;
      default: res = k;
    endcase
    flags[`FLAG_C]  = sum[8];
    flags[`FLAG_DC] = low[4];
    flags[`FLAG_Z]  = (res == 8'h00);
    flags[`FLAG_N]  = res[7];
    if (op == ALU_ADD || op == ALU_SUB)
      flag_mask = 5'h1f;
    else if (op == ALU_AND || op == ALU_OR || op == ALU_XOR)
      flag_mask = 5'h14;
  end
endmodule // constant_alu

// File: src/return_stack.sv
// return address stack held in flip-flops
`timescale 1ns/1ps
module return_stack #(
  parameter int DEPTH = 31,
  parameter int AW    = 20
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          push,
  input  wire logic          pop,
  input  wire logic [AW-1:0] push_data,
  output logic      [AW-1:0] top
);
  localparam int SW = $clog2(DEPTH + 1);
  logic [AW-1:0] mem_q [DEPTH];
  logic [SW-1:0] sp_q;
  // overflow keeps the deepest entries, underflow returns zero
  always_ff @(posedge clk) begin
    if (rst)
      sp_q <= '0;
    else if (push && sp_q != SW'(DEPTH))
      sp_q <= sp_q + 1'b1;
    else if (pop && sp_q != '0)
      sp_q <= sp_q - 1'b1;
  end
  always_ff @(posedge clk) begin
    if (push && sp_q != SW'(DEPTH))
      mem_q[sp_q] <= push_data;
  end
  assign top = (sp_q == '0) ? '0 : mem_q[sp_q - 1'b1];
endmodule // return_stack

// File: src/bit_control_literal_decoder.sv
// execution core for bit, control, literal and table instructions
//
// Operation
// - skip-if-clear (1011) and skip-if-set (1010) test a bit; skipped word runs empty
// - conditional branches 1110 0ccc add signed 8-bit offset; taken costs two cycles
// - call jumps to 20-bit target, pushes return, s bit saves shadow copies
// - absolute jump loads 20-bit target from two words in two cycles
// - push and pop move the return stack in one cycle, flags untouched
// - interrupt return pops, sets both interrupt enables, restores shadows when s
// - return-with-constant loads accumulator and returns in two cycles, flags kept
// - sleep enters standby; sleep and watchdog clear update timeout and powerdown
// - add constant to accumulator, updating all five arithmetic flags
// - constant minus accumulator into accumulator, updating all five flags
// - and, or, xor with constant update only zero and negative
// - pointer load takes two words: select and top nibble, then low byte
// - bank load writes 4-bit constant into bank select, no flags
// - accumulator load constant, one cycle, flags untouched
// - multiply accumulator by constant into product, flags untouched
// - table read fetches a byte into latch, with pointer update modes
// - table write sends latch to holding registers, with pointer update modes
// - a changed program counter (other than by two-word call or jump) or true test costs one extra empty cycle
// - a stray second word (1111) executes as no operation
// - bit modify of the port register uses the pin levels
// - bit modify of timer zero clears its assigned prescaler
`timescale 1ns/1ps
`include "core_params.svh"
module bit_control_literal_decoder
  import core_pkg::*;
#(
  parameter int STACK_DEPTH = `STACK_DEPTH
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic      [19:0] prog_addr,
  input  wire logic [15:0] prog_data,
  output logic      [11:0] data_addr,
  input  wire logic [7:0]  data_rdata,
  output logic      [7:0]  data_wdata,
  output logic             data_we,
  output logic      [20:0] tbl_addr,
  input  wire logic [7:0]  tbl_rdata,
  output logic      [7:0]  tbl_wdata,
  output logic             tbl_we,
  input  wire logic [7:0]  port_pins,
  input  wire logic        wake_pin,
  input  wire logic        prescaler_assigned,
  output logic             prescaler_clear,
  output logic             wdt_clear,
  output logic             soft_reset,
  output logic             standby,
  output logic             global_high_irq_enable,
  output logic             peripheral_low_irq_enable
);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [19:0] rel_target(input logic [19:0] pc, input logic [10:0] off);
    rel_target = pc + 20'h00001 + {{9{off[10]}}, off};
  endfunction

  state_type   st_q, st_d;
  logic        core_rst, run_q, wake_req_q, ack_q, swrst_seen_q;
  logic [19:0] pc_q, pc_d;
  logic        skip_q, skip_d;
  logic [15:0] first_q, first_d, instr;
  logic [7:0]  acc_q, acc_sh_q, pins_m_q, pins_s_q, tlat_q, bmask, src, bit_res;
  logic [4:0]  flags_q, flags_sh_q;
  logic [3:0]  bsr_q, bsr_sh_q;
  logic [11:0] ptr_q [3];
  logic [15:0] prod_q;
  logic [20:0] tblptr_q;
  logic        to_q, pd_q, wake_m_q, wake_s_q, soft_q;
  logic [11:0] fa;
  logic        acc_we, flag_we, push, pop, bsr_we, ptr_we, tbl_start, shadow_save;
  logic        restore, irq_set, go_sleep, wdt_c, swrst, presc, dwe, mul_we, cond;
  logic [19:0] push_val, top;
  alu_op_type  alu_op;
  logic [7:0]  alu_res;
  logic [4:0]  alu_flags, alu_mask;
  logic [15:0] alu_prod;

  assign core_rst = sys_rst | soft_q;
  assign instr    = prog_data;

  ////////////////////////////////////////////////////////////////////////////
  // pins cross in through two flip-flops
  always_ff @(posedge clk) begin
    pins_m_q <= port_pins;
    pins_s_q <= pins_m_q;
    wake_m_q <= wake_pin;
    wake_s_q <= wake_m_q;
  end

  // access bank splits low file space from the special registers
  always_comb begin
    if (instr[8])
      fa = {bsr_q, instr[7:0]};
    else if (instr[7:0] < `ACCESS_SPLIT)
      fa = {4'h0, instr[7:0]};
    else
      fa = {`ACCESS_HIGH, instr[7:0]};
    bmask   = 8'h01 << instr[11:9];
    src     = (fa == `PORT_ADDR) ? pins_s_q : data_rdata;
    case (instr[15:12])
      4'b1001: bit_res = src & ~bmask;
      4'b1000: bit_res = src | bmask;
      default: bit_res = src ^ bmask;
    endcase
    case (instr[10:8])
      3'd0:    cond = flags_q[`FLAG_Z];
      3'd1:    cond = ~flags_q[`FLAG_Z];
      3'd2:    cond = flags_q[`FLAG_C];
      3'd3:    cond = ~flags_q[`FLAG_C];
      3'd4:    cond = flags_q[`FLAG_OV];
      3'd5:    cond = ~flags_q[`FLAG_OV];
      3'd6:    cond = flags_q[`FLAG_N];
      default: cond = ~flags_q[`FLAG_N];
    endcase
  end

  constant_alu u_alu (
    .op        (alu_op),
    .acc       (acc_q),
    .k         (instr[7:0]),
    .res       (alu_res),
    .flags     (alu_flags),
    .flag_mask (alu_mask),
    .prod      (alu_prod)
  );

  return_stack #(.DEPTH(STACK_DEPTH), .AW(20)) u_stack (
    .clk       (clk),
    .rst       (core_rst),
    .push      (push),
    .pop       (pop),
    .push_data (push_val),
    .top       (top)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decode and sequencing
  always_comb begin
    st_d = st_q; pc_d = pc_q; skip_d = skip_q; first_d = first_q;
    acc_we = 1'b0; flag_we = 1'b0; mul_we = 1'b0; alu_op = ALU_MOV;
    push = 1'b0; pop = 1'b0; push_val = pc_q + 20'h00001;
    dwe = 1'b0; bsr_we = 1'b0; ptr_we = 1'b0; tbl_start = 1'b0;
    shadow_save = 1'b0; restore = 1'b0; irq_set = 1'b0; go_sleep = 1'b0;
    wdt_c = 1'b0; swrst = 1'b0; presc = 1'b0;
    if (run_q) begin
      case (st_q)
        ST_EXEC: begin
          pc_d = pc_q + 20'h00001;
          if (skip_q) begin
            skip_d = 1'b0;
          end else begin
            casez (instr)
              16'b100?_????_????_????, 16'b0111_????_????_????: begin
                dwe   = 1'b1;
                presc = (fa == `TIMER0_ADDR) & prescaler_assigned;
              end
              16'b101?_????_????_????:
                skip_d = instr[12] ? ~src[instr[11:9]] : src[instr[11:9]];
              16'b1110_0???_????_????: begin
                if (cond) begin
                  pc_d = rel_target(pc_q, {{3{instr[7]}}, instr[7:0]});
                  st_d = ST_FLUSH;
                end
              end
              16'b1101_????_????_????: begin
                pc_d = rel_target(pc_q, instr[10:0]);
                push = instr[11];
                st_d = ST_FLUSH;
              end
              16'b1110_11??_????_????: begin
                first_d = instr;
                st_d    = ST_SECOND;
              end
              `OP_SLEEP: begin
                go_sleep = 1'b1;
                st_d     = ST_SLEEP;
              end
              `OP_WDT_CLEAR: wdt_c = 1'b1;
              `OP_PUSH: push = 1'b1;
              `OP_POP: pop = 1'b1;
              `OP_SW_RESET: swrst = 1'b1;
              16'h001?: begin
                if (instr[3:1] == 3'b000 || instr[3:1] == 3'b001) begin
                  pc_d    = top;
                  pop     = 1'b1;
                  restore = instr[0];
                  irq_set = ~instr[1];
                  st_d    = ST_FLUSH;
                end
              end
              16'b0000_0000_0000_1???: begin
                first_d   = instr;
                tbl_start = 1'b1;
                st_d      = ST_TABLE;
              end
              16'b0000_0001_0000_????: bsr_we = 1'b1;
              16'b0000_1100_????_????: begin
                acc_we = 1'b1;
                pc_d   = top;
                pop    = 1'b1;
                st_d   = ST_FLUSH;
              end
              16'b0000_1111_????_????: begin
                alu_op = ALU_ADD; acc_we = 1'b1; flag_we = 1'b1;
              end
              16'b0000_1000_????_????: begin
                alu_op = ALU_SUB; acc_we = 1'b1; flag_we = 1'b1;
              end
              16'b0000_1011_????_????: begin
                alu_op = ALU_AND; acc_we = 1'b1; flag_we = 1'b1;
              end
              16'b0000_1001_????_????: begin
                alu_op = ALU_OR; acc_we = 1'b1; flag_we = 1'b1;
              end
              16'b0000_1010_????_????: begin
                alu_op = ALU_XOR; acc_we = 1'b1; flag_we = 1'b1;
              end
              16'b0000_1110_????_????: acc_we = 1'b1;
              16'b0000_1101_????_????: begin
                alu_op = ALU_MUL; mul_we = 1'b1;
              end
              // stray second words and byte operations pass as no operation
              default: ;
            endcase
          end
        end
        ST_SECOND: begin
          // the target is fetched at once, so no extra empty cycle follows
          st_d = ST_EXEC;
          pc_d = pc_q + 20'h00001;
          if (first_q[9:8] == 2'b10) begin
            ptr_we = 1'b1;
          end else begin
            pc_d        = {instr[11:0], first_q[7:0]};
            push        = ~first_q[9];
            shadow_save = ~first_q[9] & first_q[8];
          end
        end
        ST_FLUSH: st_d = ST_EXEC;
        ST_TABLE: st_d = ST_EXEC;
        ST_SLEEP: if (wake_s_q || wake_req_q) st_d = ST_EXEC;
        default: st_d = ST_EXEC;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (core_rst) begin
      st_q    <= ST_EXEC;
      pc_q    <= 20'h00000;
      skip_q  <= 1'b0;
      first_q <= 16'h0000;
    end else begin
      st_q    <= st_d;
      pc_q    <= pc_d;
      skip_q  <= skip_d;
      first_q <= first_d;
    end
  end

  // accumulator, flags, product and shadow copies
  always_ff @(posedge clk) begin
    if (core_rst) begin
      acc_q <= 8'h00; flags_q <= 5'h00; prod_q <= 16'h0000;
      acc_sh_q <= 8'h00; flags_sh_q <= 5'h00; bsr_sh_q <= 4'h0;
    end else begin
      if (restore) begin
        acc_q   <= acc_sh_q;
        flags_q <= flags_sh_q;
      end else begin
        if (acc_we)
          acc_q <= alu_res;
        if (flag_we)
          flags_q <= (flags_q & ~alu_mask) | (alu_flags & alu_mask);
      end
      if (mul_we)
        prod_q <= alu_prod;
      if (shadow_save) begin
        acc_sh_q <= acc_q; flags_sh_q <= flags_q; bsr_sh_q <= bsr_q;
      end
    end
  end

  // bank select and indirect pointers
  always_ff @(posedge clk) begin
    if (core_rst) begin
      bsr_q <= 4'h0;
      for (int i = 0; i < 3; i++)
        ptr_q[i] <= 12'h000;
    end else begin
      if (restore)
        bsr_q <= bsr_sh_q;
      else if (bsr_we)
        bsr_q <= instr[3:0];
      if (ptr_we)
        ptr_q[first_q[5:4]] <= {first_q[3:0], instr[7:0]};
    end
  end

  // table pointer and latch: pre-increment in the first cycle, access in the second
  always_ff @(posedge clk) begin
    if (core_rst) begin
      tblptr_q <= 21'h000000;
      tlat_q   <= 8'h00;
    end else if (tbl_start && first_d[1:0] == 2'b11) begin
      tblptr_q <= tblptr_q + 21'h000001;
    end else if (st_q == ST_TABLE && run_q) begin
      if (!first_q[2])
        tlat_q <= tbl_rdata;
      if (first_q[1:0] == 2'b01)
        tblptr_q <= tblptr_q + 21'h000001;
      else if (first_q[1:0] == 2'b10)
        tblptr_q <= tblptr_q - 21'h000001;
    end
  end

  // interrupt enables, power status and software reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      to_q <= 1'b1; pd_q <= 1'b1; soft_q <= 1'b0; swrst_seen_q <= 1'b0;
      global_high_irq_enable <= 1'b0; peripheral_low_irq_enable <= 1'b0;
    end else begin
      soft_q <= swrst;
      if (swrst || wdt_c) begin
        to_q <= 1'b1; pd_q <= 1'b1;
      end else if (go_sleep) begin
        to_q <= 1'b1; pd_q <= 1'b0;
      end
      if (swrst)
        swrst_seen_q <= 1'b1;
      else if (avs_write && ack_q && avs_address == `REG_CTRL && avs_writedata[`CTRL_SWCLR_BIT])
        swrst_seen_q <= 1'b0;
      if (soft_q) begin
        global_high_irq_enable <= 1'b0; peripheral_low_irq_enable <= 1'b0;
      end else if (irq_set) begin
        global_high_irq_enable <= 1'b1; peripheral_low_irq_enable <= 1'b1;
      end
    end
  end

  // one-cycle strobes toward prescaler and watchdog timer logic
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prescaler_clear <= 1'b0; wdt_clear <= 1'b0;
    end else begin
      prescaler_clear <= presc;
      wdt_clear       <= wdt_c;
    end
  end

  assign prog_addr  = pc_q;
  assign data_addr  = fa;
  assign data_wdata = bit_res;
  assign data_we    = dwe;
  assign tbl_addr   = tblptr_q;
  assign tbl_wdata  = tlat_q;
  assign tbl_we     = (st_q == ST_TABLE) & run_q & first_q[2];
  assign soft_reset = soft_q;
  assign standby    = (st_q == ST_SLEEP);

  ////////////////////////////////////////////////////////////////////////////
  // register bus: one wait state, then the answer
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_q <= 1'b0; run_q <= `CTRL_RUN_RST; wake_req_q <= 1'b0;
      avs_readdata <= 32'h00000000;
    end else begin
      ack_q      <= (avs_read | avs_write) & ~ack_q;
      wake_req_q <= 1'b0;
      if (avs_write && ack_q && avs_address == `REG_CTRL) begin
        run_q      <= avs_writedata[`CTRL_RUN_BIT];
        wake_req_q <= avs_writedata[`CTRL_WAKE_BIT];
      end
      if (avs_read && !ack_q) begin
        case (avs_address)
          `REG_CTRL:   avs_readdata <= {28'h0, swrst_seen_q, 2'b00, run_q};
          `REG_PC:     avs_readdata <= {3'b000, peripheral_low_irq_enable,
                                        global_high_irq_enable, pd_q, to_q, standby,
                                        4'h0, pc_q};
          `REG_CORE:   avs_readdata <= {12'h000, bsr_q, 3'b000, flags_q, acc_q};
          `REG_PROD:   avs_readdata <= {16'h0000, prod_q};
          `REG_PTR01:  avs_readdata <= {4'h0, ptr_q[1], 4'h0, ptr_q[0]};
          `REG_TBLPTR: avs_readdata <= {11'h000, tblptr_q};
          `REG_PTR2:   avs_readdata <= {12'h000, tlat_q, ptr_q[2]};
          default:     avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // bit_control_literal_decoder

// File: testbench/decoder_checker_sva.sv
// port assertions for the bit, control and literal execution core
`timescale 1ns/1ps
`include "core_params.svh"
module decoder_checker (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input wire logic [15:0] prog_data,
  input wire logic [11:0] data_addr,
  input wire logic [7:0]  data_rdata,
  input wire logic [7:0]  data_wdata,
  input wire logic        data_we,
  input wire logic        tbl_we,
  input wire logic        prescaler_assigned,
  input wire logic        prescaler_clear,
  input wire logic        wdt_clear,
  input wire logic        soft_reset,
  input wire logic        standby,
  input wire logic        global_high_irq_enable,
  input wire logic        peripheral_low_irq_enable
);
  logic [7:0] bmask;
  logic [7:0] bexp;
  assign bmask = 8'h01 << prog_data[11:9];
  always_comb begin
    case (prog_data[15:12])
      4'h9: bexp = data_rdata & ~bmask;
      4'h8: bexp = data_rdata | bmask;
      default: bexp = data_rdata ^ bmask;
    endcase
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////
  AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held too long");
  AST_WAIT_MIN: assert property (!avs_waitrequest && (avs_read || avs_write) |-> $past(avs_waitrequest))
    else $error("answer without wait cycle");
  // port writes use synchronised pins, so those are judged elsewhere
  AST_BIT_DATA: assert property (data_we && data_addr != `PORT_ADDR |-> data_wdata == bexp)
    else $error("bit modify wrong value");
  AST_BIT_ONLY: assert property (data_we |-> prog_data[15:12] inside {4'h7, 4'h8, 4'h9})
    else $error("data write from non bit op");
  AST_PRESC: assert property (prescaler_clear |-> $past(data_we) && $past(prescaler_assigned)
    && $past(data_addr) == `TIMER0_ADDR) else $error("stray prescaler clear");
  AST_WDT: assert property (wdt_clear |-> $past(prog_data) == `OP_WDT_CLEAR ##1 !wdt_clear)
    else $error("stray watchdog clear");
  AST_STBY: assert property ($rose(standby) |-> $past(prog_data) == `OP_SLEEP)
    else $error("standby without sleep");
  AST_SOFT: assert property (soft_reset |-> $past(prog_data) == `OP_SW_RESET ##1 !soft_reset)
    else $error("stray software reset");
  AST_IRQ: assert property ($rose(global_high_irq_enable) |-> peripheral_low_irq_enable
    && $past(prog_data[15:1]) == 15'h0008) else $error("enables not from interrupt return");
  AST_TBLWE: assert property (tbl_we |-> $past(prog_data[15:2]) == 14'h0003 ##1 !tbl_we)
    else $error("stray table write");
endmodule // decoder_checker

bind bit_control_literal_decoder decoder_checker i_decoder_checker (
  .clk, .sys_rst, .avs_read, .avs_write, .avs_waitrequest, .prog_data, .data_addr, .data_rdata,
  .data_wdata, .data_we, .tbl_we, .prescaler_assigned, .prescaler_clear, .wdt_clear,
  .soft_reset, .standby, .global_high_irq_enable, .peripheral_low_irq_enable
);

// File: testbench/core_memory_model.sv
// program, data and table memories facing the core
`timescale 1ns/1ps
module core_memory_model (
  input  wire logic        clk,
  input  wire logic [19:0] prog_addr,
  output logic      [15:0] prog_data,
  input  wire logic [11:0] data_addr,
  output logic      [7:0]  data_rdata,
  input  wire logic [7:0]  data_wdata,
  input  wire logic        data_we,
  input  wire logic [20:0] tbl_addr,
  output logic      [7:0]  tbl_rdata,
  input  wire logic [7:0]  tbl_wdata,
  input  wire logic        tbl_we
);
  logic [15:0] pmem[256];
  logic [7:0]  dmem[4096];
  logic [7:0]  tmem[256];
  // empty program words read as no operation
  initial begin
    foreach (pmem[i]) pmem[i] = 16'h0000;
    foreach (dmem[i]) dmem[i] = 8'(i * 37);
    foreach (tmem[i]) tmem[i] = 8'(i);
  end
  assign prog_data  = pmem[prog_addr[7:0]];
  assign data_rdata = dmem[data_addr];
  assign tbl_rdata  = tmem[tbl_addr[7:0]];
  // plain always: the initial block above also fills these arrays
  always @(posedge clk) begin
    if (data_we) dmem[data_addr] <= data_wdata;
    if (tbl_we) tmem[tbl_addr[7:0]] <= tbl_wdata;
  end
endmodule // core_memory_model

// File: testbench/bit_control_literal_decoder_tb.sv
// self-checking bench for the execution core
`timescale 1ns/1ps
`include "core_params.svh"
module bit_control_literal_decoder_tb;
  localparam int NL = 12;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, q;
  logic [19:0] prog_addr;
  logic [15:0] prog_data, prod, w;
  logic [11:0] data_addr;
  logic [20:0] tbl_addr;
  logic [7:0]  data_rdata, data_wdata, tbl_rdata, tbl_wdata, acc, k, d0;
  logic [7:0]  port_pins = 8'h00;
  logic        avs_waitrequest, data_we, tbl_we, prescaler_clear, wdt_clear, soft_reset;
  logic        standby, global_high_irq_enable, peripheral_low_irq_enable, c, dc, z, ov, n;
  logic        wake_pin = 1'b0;
  logic        prescaler_assigned = 1'b1;
  logic [3:0]  bank;
  logic [15:0] words[$];
  logic [7:0]  codes[8] = '{8'h0f, 8'h08, 8'h0b, 8'h09, 8'h0a, 8'h0e, 8'h0d, 8'h01};
  // jump over, port bit, set bit, skip, watchdog, timer bit, call, sleep, interrupt return
  logic [15:0] tail[11] = '{16'hd001, 16'h0e55, 16'h8081, 16'h8610, 16'ha610, 16'h0e55,
                            16'h0004, 16'h90d6, 16'hd801, 16'h0003, 16'h0010};
  int          pc, error_cnt, tests_run;

  bit_control_literal_decoder i_bit_control_literal_decoder (
    .clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .prog_addr, .prog_data, .data_addr, .data_rdata, .data_wdata, .data_we,
    .tbl_addr, .tbl_rdata, .tbl_wdata, .tbl_we, .port_pins, .wake_pin, .prescaler_assigned,
    .prescaler_clear, .wdt_clear, .soft_reset, .standby, .global_high_irq_enable,
    .peripheral_low_irq_enable);
  core_memory_model i_core_memory_model (.clk, .prog_addr, .prog_data, .data_addr,
    .data_rdata, .data_wdata, .data_we, .tbl_addr, .tbl_rdata, .tbl_wdata, .tbl_we);

  always #50 clk = ~clk;
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // request held until the edge where waitrequest is low
  task automatic bus(input bit wr, input logic [4:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // one idle edge so the next request never reassigns a strobe in this step
    @(posedge clk);
  endtask
  task automatic wait_lvl(input logic v);
    int t;
    t = 0;
    do begin
      @(negedge clk);
      t++;
    end while (standby !== v && t < 100);
    chk("standby", {31'h0, v}, {31'h0, standby});
    @(posedge clk);
  endtask
  task automatic apply(input logic [15:0] x);
    logic [8:0] r;
    k = x[7:0];
    case (x[15:8])
      8'h0f: begin
        r = acc + k;
        dc = (acc[3:0] + k[3:0]) > 5'd15;
        ov = (acc[7] == k[7]) && (r[7] != acc[7]);
        c = r[8];
        acc = r[7:0];
      end
      8'h08: begin
        r = {1'b0, k} - {1'b0, acc};
        dc = k[3:0] >= acc[3:0];
        ov = (k[7] != acc[7]) && (r[7] != k[7]);
        c = !r[8];
        acc = r[7:0];
      end
      8'h0b: acc = acc & k;
      8'h09: acc = acc | k;
      8'h0a: acc = acc ^ k;
      8'h0e: acc = k;
      8'h0d: prod = acc * k;
      default: bank = k[3:0];
    endcase
    if (x[15:8] inside {8'h0f, 8'h08, 8'h0b, 8'h09, 8'h0a}) begin
      z = acc == 8'h00;
      n = acc[7];
    end
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    void'($urandom(32'h155bbce9));
    port_pins <= 8'($urandom);
    {acc, bank, prod, c, dc, z, ov, n} = '0;
    // the memory model clears its program at time zero, so load after that
    repeat (2) @(posedge clk);
    for (int i = 0; i < NL; i++) begin
      w = {codes[$urandom % 8], 8'($urandom)};
      if (w[15:8] == 8'h01) w[7:4] = 4'h0;
      words.push_back(w);
      i_core_memory_model.pmem[2 * i] = w;
      i_core_memory_model.pmem[2 * i + 1] = `OP_SLEEP;
    end
    foreach (tail[j]) i_core_memory_model.pmem[2 * NL + j] = tail[j];
    sys_rst <= 1'b0;
    d0 = i_core_memory_model.dmem[12'h010];
    bus(0, `REG_CTRL, 32'h0);
    chk("ctrl", 32'h0, q);
    bus(0, `REG_PC, 32'h0);
    chk("status", 32'h0600_0000, q);
    bus(0, 5'h1c, 32'h0);
    chk("unmapped", 32'h0, q);
    bus(1, `REG_CTRL, 32'h1);
    for (int i = 0; i < NL; i++) begin
      wait_lvl(1'b0);
      wait_lvl(1'b1);
      apply(words[i]);
      pc += 2;
      bus(0, `REG_CORE, 32'h0);
      chk("core", {12'h0, bank, 3'h0, n, ov, z, dc, c, acc}, q);
      bus(0, `REG_PROD, 32'h0);
      chk("prod", {16'h0, prod}, q);
      bus(0, `REG_PC, 32'h0);
      chk("status", 32'h0300_0000 | 32'(pc), q);
      bus(1, `REG_CTRL, 32'h3);
    end
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    bus(0, `REG_PC, 32'h0);
    chk("status", 32'h1b00_0000 | 32'(pc + 10), q);
    bus(0, `REG_CORE, 32'h0);
    chk("core", {12'h0, bank, 3'h0, n, ov, z, dc, c, acc}, q);
    chk("bit", {24'h0, d0 | 8'h08}, {24'h0, i_core_memory_model.dmem[12'h010]});
    chk("pins", {24'h0, port_pins | 8'h01}, {24'h0, i_core_memory_model.dmem[12'hf81]});
    test_done;
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    test_done;
  end
endmodule // bit_control_literal_decoder_tb
